// ===== rtl/qwd_defines.vh
// Constants for the quadrature wheel decoder: register indices, field positions,
// reset values and timing counts. Included by the decoder top module and the bus checker.
`ifndef QWD_DEFINES_VH
`define QWD_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define QWD_IDX_SYSRST 8'h60
`define QWD_IDX_COUNT 8'hd0
`define QWD_IDX_CFG 8'hd1
`define QWD_IDX_SELA 8'hd2
`define QWD_IDX_SELB 8'hd3
`define QWD_IDX_RSVD 8'hd6
`define QWD_IDX_ACC 8'hd7
`define QWD_IDX_LOAD 8'hd8

// Field positions.
`define QWD_SYSRST_DEC_BIT 5
`define QWD_CFG_FILT_MSB 2
`define QWD_CFG_POL_BIT 4
`define QWD_CFG_SHUTTLE_BIT 5
`define QWD_SEL_MSB 2
`define QWD_ACC_DOUBLE_BIT 0
`define QWD_LOAD_BIT 0
`define QWD_RSVD_BIT 0

// Reset values.
`define QWD_RST_COUNT 8'h00
`define QWD_RST_CFG 8'h00
`define QWD_RST_SELA 3'h0
`define QWD_RST_SELB 3'h1
`define QWD_RST_ACC 1'b1
`define QWD_RST_LOAD 1'b0
`define QWD_RST_SYSRST 1'b0

// Timing: system clock frequency in Hz, slow clock period in ns, and the divider between them.
`define QWD_SYS_CLK_HZ 20000000
`define QWD_SLOW_CLK_PERIOD_NS 31250
`define QWD_SLOW_DIV ((`QWD_SYS_CLK_HZ / 1000) * `QWD_SLOW_CLK_PERIOD_NS / 1000000)
`define QWD_SLOW_DIV_W 10

// Sample periods a level must hold: 2^(n+1)*3 slow periods at a 2^n sample period.
`define QWD_FILT_SAMPLES 3'h6
`define QWD_FILT_W 3
`define QWD_PRESC_W 8

`endif

// ===== rtl/qwd_quadrature_wheel_decoder.v
// Quadrature wheel decoder with debounce filter, pin selection, snapshot count
// register and a classic Wishbone register slave.
// Assumes pin inputs are asynchronous to clk and that software drives the bus
// with single classic cycles.
// Assumes clk runs at 20 MHz; the slow-clock divider is built on that figure.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "qwd_defines.vh"

module qwd_quadrature_wheel_decoder (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Candidate phase pins: PA[2], PA[3], PB[6], PB[7], PC[2], PC[3], PD[6], PD[7]
    input wire [7:0] pinIn
);

    // Picks one of the eight synchronised candidate pins.
    function pickPin;
        input [7:0] pins;
        input [2:0] sel;
        begin
            pickPin = pins[sel];
        end
    endfunction

    // Debounce step: returns {new filtered level, new run length}.
    // A change is accepted only when the run of differing samples fills the window;
    // one agreeing sample restarts the run, which is what drops short glitches.
    function [`QWD_FILT_W:0] filtStep;
        input sample;
        input level;
        input [`QWD_FILT_W-1:0] run;
        begin
            if (sample == level) begin
                filtStep = {level, {`QWD_FILT_W{1'b0}}};
            end else if (run == `QWD_FILT_SAMPLES - 3'h1) begin
                filtStep = {sample, {`QWD_FILT_W{1'b0}}};
            end else begin
                filtStep = {level, run + 3'h1};
            end
        end
    endfunction

    // Register file.
    reg [7:0] snapshot_reg;
    reg [2:0] filtN_reg;
    reg polarity_reg;
    reg shuttle_reg;
    reg [2:0] selA_reg;
    reg [2:0] selB_reg;
    reg rsvd_reg;
    reg doubleMode_reg;
    reg loadReq_reg;
    reg decReset_reg;

    // Decoder state.
    reg [7:0] pinMeta_reg;
    reg [7:0] pinSync_reg;
    reg [`QWD_SLOW_DIV_W-1:0] slowDiv_reg;
    reg [`QWD_PRESC_W-1:0] presc_reg;
    reg filtA_reg;
    reg filtB_reg;
    reg [`QWD_FILT_W-1:0] runA_reg;
    reg [`QWD_FILT_W-1:0] runB_reg;
    reg prevA_reg;
    reg prevB_reg;
    reg [7:0] edgeCount_reg;

    // Bus decode and decoder datapath nets.
    wire [7:0] regIdx;
    wire access;
    wire doWrite;
    wire doRead;
    wire slowTick;
    wire sampleTick;
    wire [`QWD_PRESC_W-1:0] prescMax;
    wire rawA;
    wire rawB;
    wire [`QWD_FILT_W:0] stepA;
    wire [`QWD_FILT_W:0] stepB;
    wire edgeA;
    wire edgeB;
    reg countUp;
    reg countDown;
    reg [31:0] readData;
    wire loadWrite;
    wire countRead;
    wire [7:0] cfgReset;

    assign regIdx = wb_adr_i[9:2];
    assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign doWrite = access & wb_we_i & wb_sel_i[0];
    assign doRead = access & ~wb_we_i;
    // A load request and a count read are decoded once and used by the snapshot logic.
    assign loadWrite = doWrite & (regIdx == `QWD_IDX_LOAD) & wb_dat_i[`QWD_LOAD_BIT];
    assign countRead = doRead & (regIdx == `QWD_IDX_COUNT);
    assign cfgReset = `QWD_RST_CFG;

    // Wishbone: one wait state, ack for exactly one cycle, unmapped reads return zero.
    // Read data is latched at the accepting edge and then held, so the master takes
    // it at the ack edge with no combinational path from the address. A request is
    // only taken while ack is low, so a strobe held into the ack cycle is served once.
    always @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            if (doRead) begin
                wb_dat_o <= readData;
            end
        end
    end

    // Read mux. Unused bits and unmapped indices read as zero, the reserved bit reads back as written, and unmapped
    // indices are still acknowledged, so a stray access can never hang the bus.
    // The internal counter has no index of its own.
    always @* begin
        readData = 32'h0000_0000;
        case (regIdx)
            `QWD_IDX_SYSRST: readData[`QWD_SYSRST_DEC_BIT] = decReset_reg;
            `QWD_IDX_COUNT: readData[7:0] = snapshot_reg;
            `QWD_IDX_CFG: begin
                readData[`QWD_CFG_FILT_MSB:0] = filtN_reg;
                readData[`QWD_CFG_POL_BIT] = polarity_reg;
                readData[`QWD_CFG_SHUTTLE_BIT] = shuttle_reg;
            end
            `QWD_IDX_SELA: readData[`QWD_SEL_MSB:0] = selA_reg;
            `QWD_IDX_SELB: readData[`QWD_SEL_MSB:0] = selB_reg;
            `QWD_IDX_RSVD: readData[`QWD_RSVD_BIT] = rsvd_reg;
            `QWD_IDX_ACC: readData[`QWD_ACC_DOUBLE_BIT] = doubleMode_reg;
            `QWD_IDX_LOAD: readData[`QWD_LOAD_BIT] = loadReq_reg;
            default: readData = 32'h0000_0000;
        endcase
    end

    // Configuration registers. Writes act on the low byte lane only; a write with
    // sel[0] low is dropped whole, so a narrow write never half-updates a field.
    always @(posedge clk) begin
        if (sys_rst) begin
            filtN_reg <= cfgReset[`QWD_CFG_FILT_MSB:0];
            polarity_reg <= cfgReset[`QWD_CFG_POL_BIT];
            shuttle_reg <= cfgReset[`QWD_CFG_SHUTTLE_BIT];
            selA_reg <= `QWD_RST_SELA;
            selB_reg <= `QWD_RST_SELB;
            rsvd_reg <= 1'b0;
            doubleMode_reg <= `QWD_RST_ACC;
            decReset_reg <= `QWD_RST_SYSRST;
        end else if (doWrite) begin
            case (regIdx)
                `QWD_IDX_SYSRST: decReset_reg <= wb_dat_i[`QWD_SYSRST_DEC_BIT];
                `QWD_IDX_CFG: begin
                    filtN_reg <= wb_dat_i[`QWD_CFG_FILT_MSB:0];
                    polarity_reg <= wb_dat_i[`QWD_CFG_POL_BIT];
                    shuttle_reg <= wb_dat_i[`QWD_CFG_SHUTTLE_BIT];
                end
                `QWD_IDX_SELA: selA_reg <= wb_dat_i[`QWD_SEL_MSB:0];
                `QWD_IDX_SELB: selB_reg <= wb_dat_i[`QWD_SEL_MSB:0];
                `QWD_IDX_RSVD: rsvd_reg <= wb_dat_i[`QWD_RSVD_BIT];
                `QWD_IDX_ACC: doubleMode_reg <= wb_dat_i[`QWD_ACC_DOUBLE_BIT];
                default: decReset_reg <= decReset_reg;
            endcase
        end
    end

    // Load request and snapshot. A pending load is served on the cycle after the
    // write, so a read issued after the load bit reads zero always sees fresh data.
    // A new load request wins over the self-clear, and a pending copy wins over the
    // clear-on-read, so neither a request nor a count is ever lost.
    always @(posedge clk) begin
        if (sys_rst) begin
            loadReq_reg <= `QWD_RST_LOAD;
            snapshot_reg <= `QWD_RST_COUNT;
        end else begin
            if (loadWrite) begin
                loadReq_reg <= 1'b1;
            end else if (loadReq_reg) begin
                loadReq_reg <= 1'b0;
            end
            if (loadReq_reg) begin
                snapshot_reg <= edgeCount_reg;
            end else if (countRead) begin
                snapshot_reg <= 8'h00;
            end
        end
    end

    // Pin synchroniser: the first stage feeds only the second.
    // Every candidate pin is synchronised, not only the two selected ones, so a
    // selector change never hands a metastable stage to the decoder.
    always @(posedge clk) begin
        if (sys_rst) begin
            pinMeta_reg <= 8'h00;
            pinSync_reg <= 8'h00;
        end else begin
            pinMeta_reg <= pinIn;
            pinSync_reg <= pinMeta_reg;
        end
    end

    // The decoder is paced by a slow-clock tick made from clk, so it keeps the
    // same timing as a true slow-clock domain without a second clock tree.
    assign slowTick = (slowDiv_reg == `QWD_SLOW_DIV - 1);
    assign prescMax = (8'h01 << filtN_reg) - 8'h01;
    assign sampleTick = slowTick && (presc_reg == prescMax);

    always @(posedge clk) begin
        if (sys_rst) begin
            slowDiv_reg <= {`QWD_SLOW_DIV_W{1'b0}};
            presc_reg <= {`QWD_PRESC_W{1'b0}};
        end else begin
            if (slowTick) begin
                slowDiv_reg <= {`QWD_SLOW_DIV_W{1'b0}};
            end else begin
                slowDiv_reg <= slowDiv_reg + 10'h001;
            end
            // The prescaler is also cleared when it lies above a newly written, smaller
            // limit; left alone it would run on to its wrap-around and stall sampling
            // for up to 256 slow periods.
            if (sampleTick || presc_reg > prescMax) begin
                presc_reg <= {`QWD_PRESC_W{1'b0}};
            end else if (slowTick) begin
                presc_reg <= presc_reg + 8'h01;
            end
        end
    end

    // Selected pins, turned so that the idle level is always low inside.
    // Polarity is applied after selection, so both channels share one idle level.
    assign rawA = pickPin(pinSync_reg, selA_reg) ^ polarity_reg;
    assign rawB = pickPin(pinSync_reg, selB_reg) ^ polarity_reg;
    assign stepA = filtStep(rawA, filtA_reg, runA_reg);
    assign stepB = filtStep(rawB, filtB_reg, runB_reg);

    // Debounce: a level is taken only after it held for six sample periods.
    // prevA/prevB follow the filtered levels every clk, so each accepted edge shows
    // as a one-cycle pulse on edgeA/edgeB.
    always @(posedge clk) begin
        if (sys_rst) begin
            filtA_reg <= 1'b0;
            filtB_reg <= 1'b0;
            runA_reg <= {`QWD_FILT_W{1'b0}};
            runB_reg <= {`QWD_FILT_W{1'b0}};
            prevA_reg <= 1'b0;
            prevB_reg <= 1'b0;
        end else begin
            if (sampleTick) begin
                filtA_reg <= stepA[`QWD_FILT_W];
                runA_reg <= stepA[`QWD_FILT_W-1:0];
                filtB_reg <= stepB[`QWD_FILT_W];
                runB_reg <= stepB[`QWD_FILT_W-1:0];
            end
            prevA_reg <= filtA_reg;
            prevB_reg <= filtB_reg;
        end
    end

    assign edgeA = filtA_reg ^ prevA_reg;
    assign edgeB = filtB_reg ^ prevB_reg;

    // Direction decode. Both phases cannot change in one sample period if the
    // encoder keeps its edge spacing; a simultaneous change is dropped as invalid.
    // Double mode with A leading: the moving phase ends up different from the other
    // phase when A moves and equal to it when B moves, and both are steps up; the
    // mirror cases are steps down. Common mode counts only the edge that makes the
    // two phases equal again, which is B when A leads.
    // Limitation: shuttle mode takes A pulses as forward and B pulses as backward;
    // a wheel wired the other way round counts in reverse.
    always @* begin
        countUp = 1'b0;
        countDown = 1'b0;
        if (edgeA != edgeB) begin
            if (shuttle_reg) begin
                // Non-overlapping pulses: A pulses count up, B pulses down.
                if (edgeA && (doubleMode_reg || filtA_reg)) begin
                    countUp = 1'b1;
                end
                if (edgeB && (doubleMode_reg || filtB_reg)) begin
                    countDown = 1'b1;
                end
            end else if (doubleMode_reg) begin
                // Every edge of either phase counts.
                countUp = edgeA ? (filtA_reg != filtB_reg) : (filtB_reg == filtA_reg);
                countDown = ~countUp;
            end else if (filtA_reg == filtB_reg) begin
                // Count only when the second phase has made the matching edge.
                countUp = edgeB;
                countDown = edgeA;
            end
        end
    end

    // Internal edge counter, never mapped onto the bus.
    // The decoder reset bit is a level: the counter stays at zero until software
    // clears the bit again, so a wheel turned meanwhile is not counted.
    // The decode never raises both directions in one cycle, so the order of the two
    // branches below carries no meaning.
    always @(posedge clk) begin
        if (sys_rst || decReset_reg) begin
            edgeCount_reg <= 8'h00;
        end else if (countUp) begin
            edgeCount_reg <= edgeCount_reg + 8'h01;
        end else if (countDown) begin
            edgeCount_reg <= edgeCount_reg - 8'h01;
        end
    end

    // The internal counter has no bus index; software sees it only through a load
    // into the snapshot, which never follows the counter on its own.

endmodule

// ===== testbench/qwd_properties.sv
// Checker for the wheel decoder register bus and snapshot behaviour.
// Assumes a classic single-cycle master that drops stb between cycles.
`timescale 1ns/1ns
`include "qwd_defines.vh"
module qwd_checker (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic snapClr_reg;
    wire rdAck = wb_ack_o && !wb_we_i;
    wire [7:0] idx = wb_adr_i[9:2];
    sequence sReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence sCountRead;
        rdAck && idx == `QWD_IDX_COUNT;
    endsequence
    // A load write re-arms the snapshot, so only reads after a read must see zero.
    always @(posedge clk) begin
        if (sys_rst)
            snapClr_reg <= 1'b0;
        else if (wb_cyc_i && wb_stb_i && wb_we_i && idx == `QWD_IDX_LOAD)
            snapClr_reg <= 1'b0;
        else if (rdAck && idx == `QWD_IDX_COUNT)
            snapClr_reg <= 1'b1;
    end
    AST_ACK_NEXT: assert property (sReq |=> wb_ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    AST_READ_CLEARS: assert property (sCountRead ##0 snapClr_reg |-> wb_dat_o[7:0] == 8'h00)
        else $error("count not cleared");
    AST_LOAD_SELF_CLEAR: assert property (rdAck && idx == `QWD_IDX_LOAD |-> !wb_dat_o[0])
        else $error("load bit stuck");
    AST_UPPER_ZERO: assert property (rdAck |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper bits");
    AST_UNMAPPED: assert property (rdAck && (idx == 8'hd4 || idx == 8'hd5) |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped data");
    AST_SEL_WIDTH: assert property (rdAck && (idx == 8'hd2 || idx == 8'hd3) |-> wb_dat_o[7:3] == 5'h00)
        else $error("selector width");
endmodule
bind qwd_quadrature_wheel_decoder qwd_checker i_qwd_checker (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ===== testbench/qwd_wheel_model.sv
// Behavioural two-phase wheel driving the decoder's candidate pins.
// Assumes the bench passes the pin selectors and idle polarity it programmed.
`timescale 1ns/1ns
module qwd_wheel_model (
    // Clock and setup
    input wire clk,
    input wire [2:0] selA,
    input wire [2:0] selB,
    input wire pol,
    // Candidate pins
    output logic [7:0] pinIn
);
    localparam int GAP = 4375;
    integer seed = 32'h28e2e175;
    logic [1:0] ph = 2'd0;
    logic a = 1'b0;
    logic b = 1'b0;
    // Pins nobody selects carry noise, so a wrong selector cannot pass by luck.
    always @(posedge clk) begin
        pinIn <= $random(seed);
        pinIn[selA] <= a ^ pol;
        pinIn[selB] <= b ^ pol;
    end
    // One quadrature edge; each level holds two gaps and edges are a gap apart.
    task automatic step(input logic up);
        ph = up ? ph + 2'd1 : ph - 2'd1;
        a <= ph == 2'd1 || ph == 2'd2;
        b <= ph[1];
        repeat (GAP) @(posedge clk);
    endtask
    task automatic pulse(input int ticks);
        a <= ~a;
        repeat (ticks * 625) @(posedge clk);
        a <= ~a;
        repeat (GAP) @(posedge clk);
    endtask
endmodule

// ===== testbench/qwd_quadrature_wheel_decoder_test.sv
// Self-checking bench for the quadrature wheel decoder.
// Assumes the wheel model on the pins and the bound checker.
`timescale 1ns/1ns
module qwd_quadrature_wheel_decoder_test;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'hf;
    logic [3:0] selMask = 4'hf;
    logic [31:0] datI = 32'h0000_0000;
    wire [31:0] datO;
    wire ack;
    wire [7:0] pins;
    logic [2:0] selA = 3'h0;
    logic [2:0] selB = 3'h1;
    logic pol = 1'b0;
    logic [7:0] expQ[$];
    logic [7:0] nameQ[$];
    logic [7:0] rIdx[8] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd6, 8'hd7, 8'hd8, 8'hd4};
    logic [7:0] rVal[8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
    integer failCount = 0;
    integer nTests = 0;
    integer cycles = 0;
    integer seed = 32'h28e2e175;
    qwd_quadrature_wheel_decoder i_qwd_quadrature_wheel_decoder (.clk(clk), .sys_rst(sysRst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .pinIn(pins));
    qwd_wheel_model i_qwd_wheel_model (.clk(clk), .selA(selA), .selB(selB), .pol(pol), .pinIn(pins));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic closeOut();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            failCount++;
            closeOut();
        end
    end
    // Read data is compared at the ack edge against the oldest noted value.
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && expQ.size() > 0) begin
            nTests++;
            if (datO !== {24'h00_0000, expQ[0]}) begin
                failCount++;
                $display("[FAIL] reg %h expected %h seen %h", nameQ[0], expQ[0], datO);
            end
            expQ.pop_front();
            nameQ.pop_front();
        end
    end
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        r = $random(seed);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        // Lanes, address bits and data bits the design ignores carry random values.
        sel <= {r[2:0], selMask[0]};
        adr <= {idx, r[4:3]};
        datI <= {r[31:8], d};
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        // The wheel model follows the selectors and polarity that were just written.
        if (w && selMask[0]) begin
            if (idx == 8'hd2) selA <= d[2:0];
            if (idx == 8'hd3) selB <= d[2:0];
            if (idx == 8'hd1) pol <= d[4];
        end
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        expQ.push_back(e);
        nameQ.push_back(idx);
        bus(1'b0, idx, 8'h00);
    endtask
    task automatic loadRead(input logic [7:0] e);
        bus(1'b1, 8'hd8, 8'h01);
        rd(8'hd8, 8'h00);
        rd(8'hd0, e);
        rd(8'hd0, 8'h00);
        $display("test done, count %h", e);
    endtask
    task automatic decReset();
        bus(1'b1, 8'h60, 8'h20);
        repeat (2) @(posedge clk);
        bus(1'b1, 8'h60, 8'h00);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        sysRst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(rIdx[i], rVal[i]);
        bus(1'b1, 8'hd4, 8'hff);
        selMask <= 4'he;
        bus(1'b1, 8'hd1, 8'h07);
        selMask <= 4'hf;
        rd(8'hd1, 8'h00);
        rd(8'hd4, 8'h00);
        $display("test done, reset values");
        repeat (4) i_qwd_wheel_model.step(1'b1);
        loadRead(8'h04);
        decReset();
        loadRead(8'h00);
        repeat (2) i_qwd_wheel_model.step(1'b0);
        loadRead(8'hfe);
        bus(1'b1, 8'hd7, 8'h00);
        repeat (4) i_qwd_wheel_model.step(1'b1);
        loadRead(8'h00);
        i_qwd_wheel_model.pulse(3);
        loadRead(8'h00);
        bus(1'b1, 8'hd2, 8'h05);
        bus(1'b1, 8'hd3, 8'h07);
        bus(1'b1, 8'hd1, 8'h10);
        bus(1'b1, 8'hd7, 8'h01);
        decReset();
        rd(8'hd2, 8'h05);
        repeat (2) i_qwd_wheel_model.step(1'b1);
        loadRead(8'h02);
        bus(1'b1, 8'hd1, 8'h30);
        bus(1'b1, 8'hd7, 8'h00);
        i_qwd_wheel_model.pulse(7);
        loadRead(8'h03);
        bus(1'b1, 8'hd1, 8'h31);
        i_qwd_wheel_model.pulse(7);
        loadRead(8'h03);
        closeOut();
    end
endmodule
